// ---- haptic_playback_sequencer_tb.sv ----
// self-checking bench of the playback sequencer
// assumes AXI4-Lite register access and the engine model on the far side
module haptic_playback_sequencer_tb
  import playback_pkg::*;
;
  timeunit 1ns;
  timeprecision 100ps;

  logic        aclk;
  logic        aresetn;
  logic [7:0]  awaddr;
  logic        awvalid;
  logic        awready;
  logic [31:0] wdata;
  logic [3:0]  wstrb;
  logic        wvalid;
  logic        wready;
  logic [1:0]  bresp;
  logic        bvalid;
  logic        bready;
  logic [7:0]  araddr;
  logic        arvalid;
  logic        arready;
  logic [31:0] rdata;
  logic [1:0]  rresp;
  logic        rvalid;
  logic        rready;
  logic        device_enable_pin;
  logic [7:0]  drive_level;
  logic        drive_active;
  logic        output_float;
  logic        output_pulldown;
  logic        wave_start;
  logic        wave_abort;
  logic [6:0]  wave_id;
  logic [2:0]  wave_library;
  logic        wave_done;
  logic        seq_busy;
  int          bad_count;
  int          compares;
  int          aborts;
  logic [7:0]  seed;
  logic [7:0]  slot_v [8];
  logic [9:0]  got_q [$];
  logic [9:0]  exp_q [$];
  logic [31:0] d;
  logic [1:0]  r;

  playback_sequencer #(.TICK_CYCLS(4)) u_dut
  (
    .aclk(aclk), .aresetn(aresetn),
    .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
    .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
    .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
    .device_enable_pin(device_enable_pin), .drive_level(drive_level),
    .drive_active(drive_active), .output_float(output_float),
    .output_pulldown(output_pulldown), .wave_start(wave_start), .wave_abort(wave_abort),
    .wave_id(wave_id), .wave_library(wave_library), .wave_done(wave_done),
    .seq_busy(seq_busy)
  );

  wave_engine_model u_engine
  (
    .aclk(aclk), .aresetn(aresetn), .wave_start(wave_start),
    .wave_abort(wave_abort), .wave_id(wave_id), .wave_done(wave_done)
  );

  initial
  begin
    aclk = 1'b0;
    forever #12.5 aclk = ~aclk;
  end

  // engine requests as seen at the pins
  always @(negedge aclk)
  begin
    if (wave_start === 1'b1)
      got_q.push_back({wave_library, wave_id});
    if (wave_abort === 1'b1)
      aborts++;
  end

  function automatic logic [7:0] lfsr_next(input logic [7:0] s);
    return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
  endfunction : lfsr_next

  function automatic int expect_seq(input logic [2:0] lib);
    exp_q.delete();
    for (int i = 0; i < 8; i++)
    begin
      if (slot_v[i] == 8'h00)
        break;
      if (!slot_v[i][SLOT_WAIT_BIT] && lib != LIB_EMPTY)
        exp_q.push_back({lib, slot_v[i][6:0]});
    end
    return exp_q.size();
  endfunction : expect_seq

  task automatic stop_test();
    if (bad_count == 0 && compares > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask : stop_test

  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp)
    begin
      bad_count++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : check

  task automatic axi_wr(input logic [5:0] idx, input logic [7:0] v, output logic [1:0] resp);
    logic ta;
    logic tw;
    logic tb;
    tb = 1'b0;
    @(posedge aclk);
    awaddr  <= {idx, 2'b00};
    wdata   <= {24'h000000, v};
    awvalid <= 1'b1;
    wvalid  <= 1'b1;
    bready  <= 1'b1;
    while (!tb)
    begin
      @(negedge aclk);
      ta   = awvalid && awready;
      tw   = wvalid && wready;
      tb   = bvalid === 1'b1;
      resp = bresp;
      @(posedge aclk);
      if (ta)
        awvalid <= 1'b0;
      if (tw)
        wvalid <= 1'b0;
      if (tb)
        bready <= 1'b0;
    end
  endtask : axi_wr

  task automatic axi_rd(input logic [5:0] idx, output logic [31:0] v, output logic [1:0] resp);
    logic ta;
    logic tr;
    tr = 1'b0;
    @(posedge aclk);
    araddr  <= {idx, 2'b00};
    arvalid <= 1'b1;
    rready  <= 1'b1;
    while (!tr)
    begin
      @(negedge aclk);
      ta   = arvalid && arready;
      tr   = rvalid === 1'b1;
      v    = rdata;
      resp = rresp;
      @(posedge aclk);
      if (ta)
        arvalid <= 1'b0;
      if (tr)
        rready <= 1'b0;
    end
  endtask : axi_rd

  task automatic run_seq(input logic [2:0] lib, input logic cancel);
    logic [31:0] v;
    logic [1:0]  rs;
    int          n;
    int          e;
    got_q.delete();
    aborts = 0;
    for (int i = 0; i < 8; i++)
      axi_wr(IDX_SLOT0 + 6'(i), slot_v[i], rs);
    axi_wr(IDX_LIBCTL, {5'h00, lib}, rs);
    e = expect_seq(lib);
    axi_wr(IDX_GO, 8'h01, rs);
    axi_wr(IDX_LIBCTL, {5'h00, ~lib}, rs);
    if (cancel)
    begin
      axi_rd(IDX_GO, v, rs);
      check(v, 32'h1);
      axi_wr(IDX_GO, 8'h00, rs);
      e = 1;
      repeat (2) @(negedge aclk);
      check(32'(aborts), 32'h1);
    end
    v = 32'h1;
    n = 0;
    while (v[0] && n < 400)
    begin
      axi_rd(IDX_GO, v, rs);
      n++;
    end
    check(32'({seq_busy, v[0]}), 32'h0);
    check(32'(got_q.size()), 32'(e));
    for (int i = 0; i < e && i < got_q.size(); i++)
      check(32'(got_q[i]), 32'(exp_q[i]));
  endtask : run_seq

  initial
  begin
    repeat (60000) @(posedge aclk);
    bad_count++;
    stop_test();
  end

  initial
  begin
    aresetn = 1'b0;
    awaddr = 8'h00;
    awvalid = 1'b0;
    wdata = 32'h00000000;
    wstrb = 4'hF;
    wvalid = 1'b0;
    bready = 1'b0;
    araddr = 8'h00;
    arvalid = 1'b0;
    rready = 1'b0;
    device_enable_pin = 1'b1;
    bad_count = 0;
    compares = 0;
    seed = 8'h08;
    repeat (5) @(posedge aclk);
    aresetn <= 1'b1;
    repeat (6) @(posedge aclk);
    axi_rd(IDX_MODE, d, r);
    check(d, 32'h40);
    axi_rd(IDX_DRIVE, d, r);
    check(d, 32'h0);
    axi_rd(IDX_SLOT7, d, r);
    check(d, 32'h0);
    axi_rd(IDX_LIBCTL, d, r);
    check(d, 32'h1);
    axi_rd(6'h3F, d, r);
    check({d[29:0], r}, {30'h0, RESP_SLVERR});
    axi_wr(6'h3F, 8'hFF, r);
    check(32'(r), 32'(RESP_SLVERR));
    for (int i = 0; i < 8; i++)
    begin
      axi_wr(IDX_LIBCTL, 8'hE8 | 8'(i), r);
      axi_rd(IDX_LIBCTL, d, r);
      check(d, 32'(i));
    end
    axi_wr(IDX_MODE, {5'h00, MODE_DIRECT}, r);
    for (int i = 0; i < 6; i++)
    begin
      seed = lfsr_next(seed);
      if (i == 3)
        axi_wr(IDX_FORMAT, 8'h08, r);
      axi_wr(IDX_DRIVE, seed, r);
      repeat (2) @(negedge aclk);
      d = {23'h000000, 1'b1, (i >= 3) ? seed ^ SIGN_FLIP : seed};
      check(32'({drive_active, drive_level}), d);
    end
    axi_wr(IDX_LIBCTL, 8'h11, r);
    repeat (2) @(negedge aclk);
    check(32'({output_float, drive_active}), 32'h2);
    axi_wr(IDX_MODE, 8'h45, r);
    repeat (2) @(negedge aclk);
    check(32'({output_float, output_pulldown}), 32'h1);
    axi_wr(IDX_MODE, 8'h05, r);
    device_enable_pin <= 1'b0;
    repeat (8) @(negedge aclk);
    check(32'({output_float, output_pulldown}), 32'h1);
    @(posedge aclk);
    device_enable_pin <= 1'b1;
    axi_wr(IDX_MODE, {5'h00, MODE_INTERNAL}, r);
    repeat (8) @(posedge aclk);
    slot_v = '{8'h01, 8'h81, 8'h02, 8'h03, 8'h04, 8'h05, 8'h06, 8'h07};
    run_seq(3'h3, 1'b0);
    slot_v[0] = 8'h00;
    run_seq(3'h1, 1'b0);
    slot_v = '{8'h05, 8'h80, 8'h09, 8'h00, 8'h01, 8'h02, 8'h03, 8'h04};
    run_seq(LIB_EMPTY, 1'b0);
    slot_v = '{8'h3F, 8'h02, 8'h03, 8'h00, 8'h01, 8'h02, 8'h03, 8'h04};
    run_seq(LIB_RES, 1'b1);
    for (int k = 0; k < 5; k++)
    begin
      for (int j = 0; j < 8; j++)
      begin
        seed = lfsr_next(seed);
        slot_v[j] = seed[7] ? {5'h10, seed[2:0]} : seed;
      end
      seed = lfsr_next(seed);
      run_seq(seed[2:0], 1'b0);
    end
    stop_test();
  end
endmodule : haptic_playback_sequencer_tb

// ---- playback_pkg.sv ----
// constants, register map and types of the haptic playback sequencer
// assumes an AXI4-Lite master with 32-bit data and a 40 MHz aclk
// Overview of operation
// - In mode 5 the output is driven continuously from the drive value register.
// - Every host write of the drive value appears on the output immediately.
// - Drive value is signed unless the unsigned-format bit at index 0x1D is set.
// - Library-control bit 4 floats the output driver.
// - Floating only when enabled; shutdown or standby gives pull-to-ground instead.
// - The float request acts at once, even during playback.
// - Library select: 0 empty, 1-5 A-E, 6 resonant, 7 F; reset 1.
// - The library selected when the trigger is set is used for playback.
// - Slot bit 7 set: idle 10 ms times the low seven bits.
// - Slot bit 7 clear: low seven bits are a waveform identifier.
// - The identifier is an integer index into the chosen library.
// - The trigger starts playback from the slot at index 0x04.
// - After a waveform ends the next slot plays if it is non-zero.
// - Sequence stops at a zero slot or after slot index 0x0B.
// - Trigger stays high until the sequence ends; host clearing it cancels.
// - Mode 0 is internal trigger, mode 5 is direct drive.
package playback_pkg;

  // register indices; byte address is four times the index
  localparam logic [5:0] IDX_MODE    = 6'h01;
  localparam logic [5:0] IDX_DRIVE   = 6'h02;
  localparam logic [5:0] IDX_LIBCTL  = 6'h03;
  localparam logic [5:0] IDX_SLOT0   = 6'h04;
  localparam logic [5:0] IDX_SLOT7   = 6'h0B;
  localparam logic [5:0] IDX_GO      = 6'h0C;
  localparam logic [5:0] IDX_FORMAT  = 6'h1D;

  // field positions
  localparam int MODE_LSB      = 0;
  localparam int STANDBY_BIT   = 6;
  localparam int FLOAT_BIT     = 4;
  localparam int LIB_LSB       = 0;
  localparam int GO_BIT        = 0;
  localparam int FORMAT_BIT    = 3;
  localparam int SLOT_WAIT_BIT = 7;

  // reset values
  localparam logic [2:0] MODE_RST    = 3'h0;
  localparam logic       STANDBY_RST = 1'b1;
  localparam logic [7:0] DRIVE_RST   = 8'h00;
  localparam logic [2:0] LIB_RST     = 3'h1;
  localparam logic [7:0] SLOT_RST    = 8'h00;

  // operating functions
  localparam logic [2:0] MODE_INTERNAL = 3'h0;
  localparam logic [2:0] MODE_DIRECT   = 3'h5;

  // library codes
  localparam logic [2:0] LIB_EMPTY = 3'h0;
  localparam logic [2:0] LIB_RES   = 3'h6;

  // unsigned to signed conversion
  localparam logic [7:0] SIGN_FLIP = 8'h80;

  // wait unit timing
  localparam int WAIT_UNIT_MS     = 10;
  localparam int CLK_PERIOD_NS    = 25;
  localparam int WAIT_TICK_CYCLES = WAIT_UNIT_MS * 1000000 / CLK_PERIOD_NS;

  // bus responses
  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  typedef enum logic [3:0] {
    ST_IDLE  = 4'b0001,
    ST_FETCH = 4'b0010,
    ST_PLAY  = 4'b0100,
    ST_WAIT  = 4'b1000
  } seq_state_t;

endpackage : playback_pkg

// ---- playback_sequencer.sv ----
// direct drive, library/output control and eight-slot waveform sequencer
// assumes a library playback engine on aclk that pulses wave_done per waveform
//
// The AXI4-Lite register port was decided locally.
module playback_sequencer
  import playback_pkg::*;
#(
  parameter int SLOTS      = 8,
  parameter int TICK_CYCLS = WAIT_TICK_CYCLES
)
(
  // clock and reset
  input  wire logic        aclk,
  input  wire logic        aresetn,
  // axi4-lite write address
  input  wire logic [7:0]  s_axi_awaddr,
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  // axi4-lite write data
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  // axi4-lite write response
  output logic [1:0]       s_axi_bresp,
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  // axi4-lite read address
  input  wire logic [7:0]  s_axi_araddr,
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  // axi4-lite read data
  output logic [31:0]      s_axi_rdata,
  output logic [1:0]       s_axi_rresp,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready,
  // hardware enable pin
  input  wire logic        device_enable_pin,
  // output stage control
  output logic [7:0]       drive_level,
  output logic             drive_active,
  output logic             output_float,
  output logic             output_pulldown,
  // library playback engine
  output logic             wave_start,
  output logic             wave_abort,
  output logic [6:0]       wave_id,
  output logic [2:0]       wave_library,
  input  wire logic        wave_done,
  output logic             seq_busy
);

  localparam int TW = $clog2(TICK_CYCLS + 1);

  function automatic logic [5:0] reg_index(input logic [7:0] addr);
    reg_index = addr[7:2];
  endfunction : reg_index

  function automatic logic is_slot(input logic [5:0] idx);
    is_slot = (idx >= IDX_SLOT0) && (idx <= IDX_SLOT7);
  endfunction : is_slot

  // registers
  logic [2:0]  mode_reg;
  logic        standby_reg;
  logic [7:0]  drive_value_reg;
  logic [2:0]  lib_sel_reg;
  logic        float_req_reg;
  logic        unsigned_sel_reg;
  logic        go_reg;
  logic [7:0]  slot_reg [0:SLOTS-1];

  // bus state
  logic        aw_held_reg;
  logic        w_held_reg;
  logic [5:0]  wr_idx_reg;
  logic [7:0]  wr_data_reg;
  logic        wr_lane_reg;
  logic        bvalid_reg;
  logic [1:0]  bresp_reg;
  logic        rvalid_reg;
  logic [31:0] rdata_reg;
  logic [1:0]  rresp_reg;
  logic        wr_fire;
  logic        wr_en;
  logic [31:0] rd_value;
  logic        rd_mapped;

  // pin synchroniser
  logic        en_s1_reg;
  logic        en_s2_reg;
  logic        en_s3_reg;
  logic        enabled_reg;

  // sequencer
  seq_state_t  state_reg;
  logic [2:0]  slot_idx_reg;
  logic [6:0]  units_reg;
  logic [TW-1:0] tick_reg;
  logic        seq_done;
  logic [7:0]  cur_slot;
  logic        trig_ok;

  // axi write channel
  assign s_axi_awready = !aw_held_reg && !bvalid_reg;
  assign s_axi_wready  = !w_held_reg && !bvalid_reg;
  assign wr_fire       = aw_held_reg && w_held_reg && !bvalid_reg;
  assign wr_en         = wr_fire && wr_lane_reg;
  assign s_axi_bvalid  = bvalid_reg;
  assign s_axi_bresp   = bresp_reg;

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      aw_held_reg <= 1'b0;
      w_held_reg  <= 1'b0;
      wr_idx_reg  <= 6'h00;
      wr_data_reg <= 8'h00;
      wr_lane_reg <= 1'b0;
      bvalid_reg  <= 1'b0;
      bresp_reg   <= RESP_OKAY;
    end
    else
    begin
      if (s_axi_awvalid && s_axi_awready)
      begin
        aw_held_reg <= 1'b1;
        wr_idx_reg  <= reg_index(s_axi_awaddr);
      end
      if (s_axi_wvalid && s_axi_wready)
      begin
        w_held_reg  <= 1'b1;
        wr_data_reg <= s_axi_wdata[7:0];
        wr_lane_reg <= s_axi_wstrb[0];
      end
      if (wr_fire)
      begin
        aw_held_reg <= 1'b0;
        w_held_reg  <= 1'b0;
        bvalid_reg  <= 1'b1;
        bresp_reg   <= (wr_idx_reg == IDX_MODE || wr_idx_reg == IDX_DRIVE ||
                        wr_idx_reg == IDX_LIBCTL || is_slot(wr_idx_reg) ||
                        wr_idx_reg == IDX_GO || wr_idx_reg == IDX_FORMAT)
                       ? RESP_OKAY : RESP_SLVERR;
      end
      else if (bvalid_reg && s_axi_bready)
        bvalid_reg <= 1'b0;
    end
  end

  // axi read channel
  assign s_axi_arready = !rvalid_reg;
  assign s_axi_rvalid  = rvalid_reg;
  assign s_axi_rdata   = rdata_reg;
  assign s_axi_rresp   = rresp_reg;

  always_comb
  begin
    rd_value  = 32'h0000_0000;
    rd_mapped = 1'b1;
    case (reg_index(s_axi_araddr))
      IDX_MODE:   rd_value[7:0] = {1'b0, standby_reg, 3'h0, mode_reg};
      IDX_DRIVE:  rd_value[7:0] = drive_value_reg;
      IDX_LIBCTL: rd_value[7:0] = {3'h0, float_req_reg, 1'b0, lib_sel_reg};
      IDX_GO:     rd_value[7:0] = {7'h00, go_reg};
      IDX_FORMAT: rd_value[7:0] = {4'h0, unsigned_sel_reg, 3'h0};
      default:
      begin
        if (is_slot(reg_index(s_axi_araddr)))
          rd_value[7:0] = slot_reg[3'(reg_index(s_axi_araddr) - IDX_SLOT0)];
        else
          rd_mapped = 1'b0;
      end
    endcase
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      rvalid_reg <= 1'b0;
      rdata_reg  <= 32'h0000_0000;
      rresp_reg  <= RESP_OKAY;
    end
    else if (s_axi_arvalid && s_axi_arready)
    begin
      rvalid_reg <= 1'b1;
      rdata_reg  <= rd_value;
      rresp_reg  <= rd_mapped ? RESP_OKAY : RESP_SLVERR;
    end
    else if (rvalid_reg && s_axi_rready)
      rvalid_reg <= 1'b0;
  end

  // control registers
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      mode_reg         <= MODE_RST;
      standby_reg      <= STANDBY_RST;
      drive_value_reg  <= DRIVE_RST;
      lib_sel_reg      <= LIB_RST;
      float_req_reg    <= 1'b0;
      unsigned_sel_reg <= 1'b0;
    end
    else if (wr_en)
    begin
      case (wr_idx_reg)
        IDX_MODE:
        begin
          mode_reg    <= wr_data_reg[MODE_LSB +: 3];
          standby_reg <= wr_data_reg[STANDBY_BIT];
        end
        IDX_DRIVE:  drive_value_reg <= wr_data_reg;
        IDX_LIBCTL:
        begin
          lib_sel_reg   <= wr_data_reg[LIB_LSB +: 3];
          float_req_reg <= wr_data_reg[FLOAT_BIT];
        end
        IDX_FORMAT: unsigned_sel_reg <= wr_data_reg[FORMAT_BIT];
        default:    mode_reg <= mode_reg;
      endcase
    end
  end

  // sequence slots
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      for (int i = 0; i < SLOTS; i++)
        slot_reg[i] <= SLOT_RST;
    end
    else if (wr_en && is_slot(wr_idx_reg))
      slot_reg[3'(wr_idx_reg - IDX_SLOT0)] <= wr_data_reg;
  end

  // trigger bit: host write wins over the hardware clear
  assign trig_ok = (mode_reg == MODE_INTERNAL) && !standby_reg && enabled_reg;

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      go_reg <= 1'b0;
    else if (wr_en && wr_idx_reg == IDX_GO)
      go_reg <= wr_data_reg[GO_BIT] && trig_ok;
    else if (seq_done || !trig_ok)
      go_reg <= 1'b0;
  end

  // enable pin synchroniser
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      en_s1_reg   <= 1'b0;
      en_s2_reg   <= 1'b0;
      en_s3_reg   <= 1'b0;
      enabled_reg <= 1'b0;
    end
    else
    begin
      en_s1_reg <= device_enable_pin;
      en_s2_reg <= en_s1_reg;
      en_s3_reg <= en_s2_reg;
      if (en_s2_reg == en_s3_reg)
        enabled_reg <= en_s3_reg;
    end
  end

  // output stage
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      drive_level     <= 8'h00;
      drive_active    <= 1'b0;
      output_float    <= 1'b0;
      output_pulldown <= 1'b1;
    end
    else
    begin
      drive_level     <= unsigned_sel_reg ? (drive_value_reg ^ SIGN_FLIP)
                                          : drive_value_reg;
      drive_active    <= (mode_reg == MODE_DIRECT) && enabled_reg &&
                         !standby_reg && !float_req_reg;
      output_float    <= float_req_reg && enabled_reg && !standby_reg;
      output_pulldown <= !enabled_reg || standby_reg;
    end
  end

  // sequencer
  assign cur_slot = slot_reg[slot_idx_reg];
  assign seq_busy = (state_reg != ST_IDLE);
  assign seq_done = (state_reg == ST_FETCH && cur_slot == SLOT_RST) ||
                    (state_reg == ST_FETCH && !cur_slot[SLOT_WAIT_BIT] &&
                     wave_library == LIB_EMPTY && slot_idx_reg == 3'(SLOTS - 1)) ||
                    (state_reg == ST_PLAY && wave_done && slot_idx_reg == 3'(SLOTS - 1)) ||
                    (state_reg == ST_WAIT && units_reg == 7'h00 &&
                     slot_idx_reg == 3'(SLOTS - 1));

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      state_reg    <= ST_IDLE;
      slot_idx_reg <= 3'h0;
      units_reg    <= 7'h00;
      tick_reg     <= '0;
      wave_start   <= 1'b0;
      wave_abort   <= 1'b0;
      wave_id      <= 7'h00;
      wave_library <= LIB_RST;
    end
    else
    begin
      wave_start <= 1'b0;
      wave_abort <= 1'b0;
      if (state_reg != ST_IDLE && (!go_reg || seq_done))
      begin
        state_reg  <= ST_IDLE;
        wave_abort <= !go_reg;
      end
      else
      begin
        case (state_reg)
          ST_IDLE:
            if (go_reg)
            begin
              state_reg    <= ST_FETCH;
              slot_idx_reg <= 3'h0;
              wave_library <= lib_sel_reg;
            end
          ST_FETCH:
            if (cur_slot[SLOT_WAIT_BIT])
            begin
              state_reg <= ST_WAIT;
              units_reg <= cur_slot[6:0];
              tick_reg  <= '0;
            end
            else if (wave_library == LIB_EMPTY)
              slot_idx_reg <= slot_idx_reg + 3'h1;
            else
            begin
              state_reg  <= ST_PLAY;
              wave_id    <= cur_slot[6:0];
              wave_start <= 1'b1;
            end
          ST_PLAY:
            if (wave_done)
            begin
              state_reg    <= ST_FETCH;
              slot_idx_reg <= slot_idx_reg + 3'h1;
            end
          ST_WAIT:
            if (units_reg == 7'h00)
            begin
              state_reg    <= ST_FETCH;
              slot_idx_reg <= slot_idx_reg + 3'h1;
            end
            else if (tick_reg == TW'(TICK_CYCLS - 1))
            begin
              tick_reg  <= '0;
              units_reg <= units_reg - 7'h01;
            end
            else
              tick_reg <= tick_reg + TW'(1);
          default: state_reg <= ST_IDLE;
        endcase
      end
    end
  end

  // checks
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  sequence seq_trigger_s;
    state_reg == ST_IDLE && go_reg;
  endsequence

  sequence seq_first_slot_s;
    state_reg == ST_FETCH && slot_idx_reg == 3'h0;
  endsequence

  direct_signed_a: assert property (mode_reg == MODE_DIRECT && !unsigned_sel_reg
    |=> drive_level == $past(drive_value_reg))
    else $error("signed drive value not on output");

  drive_update_a: assert property (wr_en && wr_idx_reg == IDX_DRIVE && !unsigned_sel_reg
    ##1 !wr_en |=> drive_level == $past(wr_data_reg, 2))
    else $error("written drive value not applied");

  unsigned_fmt_a: assert property (unsigned_sel_reg && $stable(unsigned_sel_reg)
    |=> drive_level == ($past(drive_value_reg) ^ SIGN_FLIP))
    else $error("unsigned drive value not converted");

  float_enable_a: assert property (output_float
    |-> $past(enabled_reg) && !$past(standby_reg) && $past(float_req_reg))
    else $error("output floated while not enabled");

  float_now_a: assert property (float_req_reg && enabled_reg && !standby_reg
    |=> output_float && !drive_active)
    else $error("float request not applied at once");

  pulldown_a: assert property (standby_reg |=> output_pulldown && !output_float)
    else $error("standby without pull to ground");

  lib_latch_a: assert property (seq_trigger_s |=> seq_first_slot_s
    and (wave_library == $past(lib_sel_reg)))
    else $error("sequence start slot or library wrong");

  advance_a: assert property (state_reg == ST_PLAY && wave_done && go_reg && !seq_done
    |=> state_reg == ST_FETCH && slot_idx_reg == $past(slot_idx_reg) + 3'h1)
    else $error("sequencer did not advance");

  zero_end_a: assert property (state_reg == ST_FETCH && cur_slot == SLOT_RST
    |=> state_reg == ST_IDLE && (!go_reg || $past(wr_en)))
    else $error("zero slot did not end sequence");

  cancel_a: assert property (state_reg != ST_IDLE && !go_reg
    |=> state_reg == ST_IDLE && wave_abort)
    else $error("cleared trigger did not cancel");

  wait_step_a: assert property (state_reg == ST_WAIT && units_reg != 7'h00 && go_reg
    && tick_reg == TW'(TICK_CYCLS - 1) |=> units_reg == $past(units_reg) - 7'h01)
    else $error("wait unit not counted");

  play_id_a: assert property (wave_start |-> state_reg == ST_PLAY
    && wave_id == $past(cur_slot[6:0]))
    else $error("waveform identifier mismatch");

endmodule : playback_sequencer

// ---- wave_engine_model.sv ----
// library playback engine model: plays one waveform per wave_start
// assumes wave_start and wave_abort are one-cycle pulses on aclk
module wave_engine_model
(
  // clock and reset
  input  wire logic       aclk,
  input  wire logic       aresetn,
  // sequencer side
  input  wire logic       wave_start,
  input  wire logic       wave_abort,
  input  wire logic [6:0] wave_id,
  output logic            wave_done
);
  logic [7:0] left;

  // length picked by the identifier, so replies come prompt or slow
  always_ff @(posedge aclk)
  begin
    wave_done <= 1'b0;
    if (!aresetn || wave_abort)
      left <= 8'h00;
    else if (wave_start)
      left <= {2'h0, wave_id[5:0]} + 8'h01;
    else if (left != 8'h00)
    begin
      left      <= left - 8'h01;
      wave_done <= (left == 8'h01);
    end
  end
endmodule : wave_engine_model
